// ==== verilog/irc_ctrl.sv ====
`timescale 1ns/10ps
// Functional notes
// RULE1 - Pin edge code: 00 off, 01 rising, 10 falling, 11 both edges.
// RULE2 - Edge register: pin B field in bits 3..2, pin A in 1..0.
// RULE3 - A source event sets that source's request flag.
// RULE4 - Flag with enable clear stays set but never causes a vector jump; grouped member enables are unused, member events still set the group flag.
// RULE5 - Global enable low blocks every interrupt.
// RULE6 - Taking an interrupt pushes next address and loads the vector.
// RULE7 - Return from interrupt pops the saved address back into the PC.
// RULE8 - Taking an interrupt clears the global enable.
// RULE9 - Requests while blocked still set flags and stay pending.
// RULE10 - Full stack blocks acknowledge until the pointer decrements.
// RULE11 - Software re-enabling globally in a handler allows nesting.
// RULE12 - Any flag becoming set wakes from sleep or idle, enables ignored.
// RULE13 - Only flags newly set during low power cause the wake.
// RULE14 - Own vectors and grouped vectors; fixed priority resolves ties.
// RULE15 - Primary register 0: grp0, comp, pin A flags, enables, global.
// RULE16 - Primary register 1: tb0, conv, grp2, grp1 flags then enables.
// RULE17 - Primary register 2: uart, sim, pin B, tb1 flags then enables.
// RULE18 - Grouped register 0: std timer A,P flags 5,4; enables 1,0.
// RULE19 - Grouped register 1: compact A,P, periodic A,P flags; enables.
// RULE20 - Grouped register 2: eeprom, low-voltage flags 5,4; enables 1,0.
// RULE21 - Unused bits read zero; all fields read/write, reset zero.
// RULE22 - Pin flag sets on the transition chosen by its edge field.
// RULE23 - Servicing an own-vector source clears its flag.
// RULE24 - Grouped flag sets on any member; service clears only group flag.
// RULE25 - Priority order and vector addresses come from parameters.
module irc_ctrl #(
  parameter logic [irc_pkg::PC_W-1:0] VEC_BASE = irc_pkg::VEC_BASE_DEF,
  parameter logic [irc_pkg::PC_W-1:0] VEC_STEP = irc_pkg::VEC_STEP_DEF,
  parameter logic [irc_pkg::NVEC*4-1:0] PRIO_ORDER = irc_pkg::PRIO_DEF
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [irc_pkg::ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [irc_pkg::ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic extIrqPinA, // External pin A
  input wire logic extIrqPinB, // External pin B
  input wire irc_pkg::irc_evt_t evt, // Peripheral event pulses
  input wire irc_pkg::irc_core_req_t coreReq, // Core requests
  input wire logic lowPower, // Core in sleep or idle
  output irc_pkg::irc_core_rsp_t coreRsp, // PC load to core
  output logic [irc_pkg::SP_W-1:0] stackLevel, // Stack depth used
  output logic wakeReq // Wake request level
);
  import irc_pkg::*;

  logic [3:0] edgeSel_r;
  logic emi_r;
  logic [NVEC-1:0] vFlag_r;
  logic [NVEC-1:0] vEn_r;
  logic [NSUB-1:0] sFlag_r;
  logic [NSUB-1:0] sEn_r;
  logic [3:0] edgeSw;
  logic emiSw;
  logic [NVEC-1:0] vFlagSw;
  logic [NVEC-1:0] vEnSw;
  logic [NSUB-1:0] sFlagSw;
  logic [NSUB-1:0] sEnSw;
  logic [NVEC-1:0] vSet;
  logic [NVEC-1:0] svcClr;
  logic [NVEC-1:0] pend;
  logic wrRdy_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rdRdy_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wrFire;
  logic [2:0] pinASync_r;
  logic [2:0] pinBSync_r;
  logic hitA;
  logic hitB;
  logic [PC_W-1:0] stk [STK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] spDec;
  logic take;
  logic push;
  logic pop;
  logic [3:0] winner;
  logic [PC_W-1:0] vecAddr;
  irc_core_rsp_t coreRsp_r;
  logic [NVEC+NSUB-1:0] flagPrev_r;
  logic wake_r;
  logic [NVEC-1:0] oneHot;

  // True for an implemented register address
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a inside {OFS_EDGE, OFS_PRI0, OFS_PRI1, OFS_PRI2,
                     OFS_GRP0, OFS_GRP1, OFS_GRP2};
  endfunction

  // Edge match for one pin from its code and the sampled transition
  function automatic logic edgeHit(input logic [1:0] sel,
                                   input logic rise, input logic fall);
    return ((sel == EDGE_RISE) && rise) || ((sel == EDGE_FALL) && fall) ||
           ((sel == EDGE_BOTH) && (rise || fall));
  endfunction

  // Highest priority pending source, scanning from lowest upward
  function automatic logic [3:0] pickSrc(input logic [NVEC-1:0] p);
    logic [3:0] w;
    w = PRIO_ORDER[3:0];
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (p[PRIO_ORDER[i*4 +: 4]]) begin
        w = PRIO_ORDER[i*4 +: 4];
      end
    end
    return w;
  endfunction

  // Register read image; unused bits are zero
  // RULE21 unused read zero
  function automatic logic [7:0] regRead(input logic [ADDR_W-1:0] a);
    logic [7:0] d;
    d = REG_RESET;
    case (a)
      OFS_EDGE: d = {4'h0, edgeSel_r};
      OFS_PRI0: d = {1'b0, vFlag_r[PRI0_HI:PRI0_LO], vEn_r[PRI0_HI:PRI0_LO], emi_r};
      OFS_PRI1: d = {vFlag_r[PRI1_HI:PRI1_LO], vEn_r[PRI1_HI:PRI1_LO]};
      OFS_PRI2: d = {vFlag_r[PRI2_HI:PRI2_LO], vEn_r[PRI2_HI:PRI2_LO]};
      OFS_GRP0: d = {2'h0, sFlag_r[GRP0_HI:GRP0_LO], 2'h0, sEn_r[GRP0_HI:GRP0_LO]};
      OFS_GRP1: d = {sFlag_r[GRP1_HI:GRP1_LO], sEn_r[GRP1_HI:GRP1_LO]};
      OFS_GRP2: d = {2'h0, sFlag_r[GRP2_HI:GRP2_LO], 2'h0, sEn_r[GRP2_HI:GRP2_LO]};
      default: d = REG_RESET;
    endcase
    return d;
  endfunction

  // Write channel: both channels taken together, one response each
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrRdy_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      wrRdy_r <= awvalid && wvalid && !wrRdy_r && !bvalid_r;
      if (wrRdy_r) begin
        bvalid_r <= 1'b1;
        bresp_r <= isMapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready && bvalid_r) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: data sampled at the address handshake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdRdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      rdRdy_r <= arvalid && !rdRdy_r && !rvalid_r;
      if (rdRdy_r) begin
        rvalid_r <= 1'b1;
        rresp_r <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_r <= {24'h00_0000, regRead(araddr)};
      end else if (rready && rvalid_r) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign wrFire = wrRdy_r && wstrb[0];

  // Software view after a write: the low byte replaces the register
  always_comb begin
    edgeSw = edgeSel_r;
    emiSw = emi_r;
    vFlagSw = vFlag_r;
    vEnSw = vEn_r;
    sFlagSw = sFlag_r;
    sEnSw = sEn_r;
    if (wrFire) begin
      case (awaddr)
        // RULE2 edge fields
        OFS_EDGE: edgeSw = wdata[3:0];
        // RULE15 primary reg 0
        OFS_PRI0: begin
          vFlagSw[PRI0_HI:PRI0_LO] = wdata[6:4];
          vEnSw[PRI0_HI:PRI0_LO] = wdata[3:1];
          emiSw = wdata[0];
        end
        // RULE16 primary reg 1
        OFS_PRI1: begin
          vFlagSw[PRI1_HI:PRI1_LO] = wdata[7:4];
          vEnSw[PRI1_HI:PRI1_LO] = wdata[3:0];
        end
        // RULE17 primary reg 2
        OFS_PRI2: begin
          vFlagSw[PRI2_HI:PRI2_LO] = wdata[7:4];
          vEnSw[PRI2_HI:PRI2_LO] = wdata[3:0];
        end
        // RULE18 grouped reg 0
        OFS_GRP0: begin
          sFlagSw[GRP0_HI:GRP0_LO] = wdata[5:4];
          sEnSw[GRP0_HI:GRP0_LO] = wdata[1:0];
        end
        // RULE19 grouped reg 1
        OFS_GRP1: begin
          sFlagSw[GRP1_HI:GRP1_LO] = wdata[7:4];
          sEnSw[GRP1_HI:GRP1_LO] = wdata[3:0];
        end
        // RULE20 grouped reg 2
        OFS_GRP2: begin
          sFlagSw[GRP2_HI:GRP2_LO] = wdata[5:4];
          sEnSw[GRP2_HI:GRP2_LO] = wdata[1:0];
        end
        default: edgeSw = edgeSel_r;
      endcase
    end
  end

  // Pin synchronisers plus one history stage for edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinASync_r <= 3'h0;
      pinBSync_r <= 3'h0;
    end else begin
      pinASync_r <= {pinASync_r[1:0], extIrqPinA};
      pinBSync_r <= {pinBSync_r[1:0], extIrqPinB};
    end
  end

  // RULE1 RULE22 edge select
  assign hitA = edgeHit(edgeSel_r[PIN_A_EDGE_LO +: 2],
                        pinASync_r[1] && !pinASync_r[2], !pinASync_r[1] && pinASync_r[2]);
  assign hitB = edgeHit(edgeSel_r[PIN_B_EDGE_LO +: 2],
                        pinBSync_r[1] && !pinBSync_r[2], !pinBSync_r[1] && pinBSync_r[2]);

  // RULE3 RULE24 source set events
  always_comb begin
    vSet = '0;
    vSet[V_GRP0] = |evt.sub[GRP0_HI:GRP0_LO];
    vSet[V_GRP1] = |evt.sub[GRP1_HI:GRP1_LO];
    vSet[V_GRP2] = |evt.sub[GRP2_HI:GRP2_LO];
    vSet[V_CONV] = evt.conv;
    vSet[V_TB0] = evt.tb0;
    vSet[V_TB1] = evt.tb1;
    vSet[V_PINB] = hitB;
    vSet[V_SIM] = evt.sim;
    vSet[V_UART] = evt.uart;
    vSet[V_PINA] = hitA;
    vSet[V_COMP] = evt.comp;
  end

  // RULE4 RULE14 enabled pending and priority pick
  assign pend = vFlag_r & vEn_r;
  assign winner = pickSrc(pend);
  // RULE25 vector from parameters
  assign vecAddr = VEC_BASE + PC_W'(VEC_STEP * {9'h000, winner});

  // RULE5 RULE10 take only with global enable and room on the stack
  assign take = emi_r && (sp_r != SP_FULL) && coreReq.slot && (|pend) &&
                !coreReq.callPush && !coreReq.retPop && !coreReq.retiPop;
  assign oneHot = NVEC'(1);
  // RULE23 service clears own flag
  assign svcClr = take ? (oneHot << winner) : '0;

  // Flags: hardware set wins over software or service clear
  // RULE9 flags latch while blocked
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vFlag_r <= '0;
      sFlag_r <= '0;
    end else begin
      vFlag_r <= vSet | (vFlagSw & ~svcClr);
      // RULE24 member flags untouched by service
      sFlag_r <= evt.sub | sFlagSw;
    end
  end

  // Enables and edge selection, software owned
  // RULE21 reset to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vEn_r <= '0;
      sEn_r <= '0;
      edgeSel_r <= 4'h0;
    end else begin
      vEn_r <= vEnSw;
      sEn_r <= sEnSw;
      edgeSel_r <= edgeSw;
    end
  end

  // Global enable: cleared on entry, software may set it again
  // RULE8 RULE11 global enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      emi_r <= 1'b0;
    end else begin
      emi_r <= take ? 1'b0 : emiSw;
    end
  end

  // Stack control
  assign push = take || (coreReq.callPush && (sp_r != SP_FULL));
  assign pop = (coreReq.retPop || coreReq.retiPop) && !coreReq.callPush &&
               (sp_r != 4'h0);
  assign spDec = sp_r - 4'h1;

  // RULE6 push next address
  always_ff @(posedge mclk) begin
    if (push) begin
      stk[sp_r[2:0]] <= coreReq.pcNext;
    end
  end

  // Stack pointer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_r <= 4'h0;
    end else if (push) begin
      sp_r <= sp_r + 4'h1;
    end else if (pop) begin
      sp_r <= spDec;
    end
  end

  // RULE6 RULE7 PC load with vector or popped address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coreRsp_r <= '0;
    end else begin
      coreRsp_r.pcLoad <= take || pop;
      if (take) begin
        coreRsp_r.pcTarget <= vecAddr;
      end else if (pop) begin
        coreRsp_r.pcTarget <= stk[spDec[2:0]];
      end
    end
  end

  // RULE12 RULE13 wake on a flag newly set in low power
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flagPrev_r <= '0;
      wake_r <= 1'b0;
    end else begin
      flagPrev_r <= {vFlag_r, sFlag_r};
      wake_r <= lowPower && (wake_r || (|({vFlag_r, sFlag_r} & ~flagPrev_r)));
    end
  end

  // Outputs straight from flops
  assign awready = wrRdy_r;
  assign wready = wrRdy_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = rdRdy_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign coreRsp = coreRsp_r;
  assign stackLevel = sp_r;
  assign wakeReq = wake_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Entry and PC load as two steps
  sequence s_take;
    take;
  endsequence
  sequence s_load;
    coreRsp_r.pcLoad && (coreRsp_r.pcTarget == $past(vecAddr));
  endsequence

  property p_edge_off;
    (edgeSel_r[PIN_A_EDGE_LO +: 2] == EDGE_OFF) |-> !hitA;
  endproperty
  a_edge_off: assert property (p_edge_off) // RULE1
    else $error("pin A flagged with edge off");

  property p_no_emi;
    !emi_r |-> !take;
  endproperty
  a_no_emi: assert property (p_no_emi) // RULE5
    else $error("interrupt taken with global enable low");

  property p_need_en;
    take |-> vEn_r[winner] && vFlag_r[winner];
  endproperty
  a_need_en: assert property (p_need_en) // RULE4
    else $error("interrupt taken for disabled source");

  property p_load;
    s_take |=> s_load ##0 (sp_r == $past(sp_r) + 4'h1);
  endproperty
  a_load: assert property (p_load) // RULE6
    else $error("vector load or push missing");

  property p_return_from_interrupt_op;
    (coreReq.retiPop && !coreReq.callPush && !take && sp_r != 4'h0) |=>
      coreRsp_r.pcLoad && (sp_r == $past(spDec)) &&
      (coreRsp_r.pcTarget == $past(stk[spDec[2:0]]));
  endproperty
  a_return_from_interrupt_op: assert property (p_return_from_interrupt_op) // RULE7
    else $error("return did not restore address");

  property p_emi_clr;
    take |=> !emi_r ##1 (!emi_r || $past(wrFire));
  endproperty
  a_emi_clr: assert property (p_emi_clr) // RULE8
    else $error("global enable not cleared on entry");

  property p_pending;
    (vSet[V_COMP] && !emi_r) |=> vFlag_r[V_COMP];
  endproperty
  a_pending: assert property (p_pending) // RULE9
    else $error("blocked request lost");

  property p_full;
    (sp_r == SP_FULL) |-> !take && !push;
  endproperty
  a_full: assert property (p_full) // RULE10
    else $error("acknowledge with full stack");

  property p_wake;
    (lowPower && |({vFlag_r, sFlag_r} & ~flagPrev_r)) |=> wake_r;
  endproperty
  a_wake: assert property (p_wake) // RULE12
    else $error("no wake on new flag");

  property p_no_wake;
    (!wake_r && lowPower && ({vFlag_r, sFlag_r} == flagPrev_r)) |=> !wake_r;
  endproperty
  a_no_wake: assert property (p_no_wake) // RULE13
    else $error("wake without newly set flag");

  property p_grp_keep;
    (take && winner == 4'(V_GRP0) && !wrFire) |=>
      vFlag_r[V_GRP0] == $past(vSet[V_GRP0]) && sFlag_r == $past(sFlag_r | evt.sub);
  endproperty
  a_grp_keep: assert property (p_grp_keep) // RULE24
    else $error("group service touched member flags");
endmodule

// ==== verilog/irc_pkg.sv ====
package irc_pkg;
  // Register byte addresses on the AXI4-Lite slave
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRI0 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRI1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PRI2 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_GRP0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GRP1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_GRP2 = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Edge selection codes and field positions
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int PIN_B_EDGE_LO = 2;
  localparam int PIN_A_EDGE_LO = 0;

  // Vectored sources: index into flag/enable vectors
  localparam int NVEC = 11;
  localparam int V_GRP1 = 0;
  localparam int V_GRP2 = 1;
  localparam int V_CONV = 2;
  localparam int V_TB0 = 3;
  localparam int V_TB1 = 4;
  localparam int V_PINB = 5;
  localparam int V_SIM = 6;
  localparam int V_UART = 7;
  localparam int V_PINA = 8;
  localparam int V_COMP = 9;
  localparam int V_GRP0 = 10;
  // Slices of the vectored bits held by each primary register
  localparam int PRI0_HI = 10;
  localparam int PRI0_LO = 8;
  localparam int PRI1_HI = 3;
  localparam int PRI1_LO = 0;
  localparam int PRI2_HI = 7;
  localparam int PRI2_LO = 4;

  // Grouped sources: 0 std P, 1 std A, 2 per P, 3 per A, 4 cmp P, 5 cmp A, 6 lowv, 7 eeprom
  localparam int NSUB = 8;
  localparam int GRP0_HI = 1;
  localparam int GRP0_LO = 0;
  localparam int GRP1_HI = 5;
  localparam int GRP1_LO = 2;
  localparam int GRP2_HI = 7;
  localparam int GRP2_LO = 6;

  // Program counter and stack
  localparam int PC_W = 13;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam logic [SP_W-1:0] SP_FULL = 4'h8;

  // Vector table and priority defaults; element 0 of the order is highest
  localparam logic [PC_W-1:0] VEC_BASE_DEF = 13'h0004;
  localparam logic [PC_W-1:0] VEC_STEP_DEF = 13'h0004;
  localparam logic [NVEC*4-1:0] PRIO_DEF =
    {4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'ha, 4'h9, 4'h8};

  // Peripheral event pulses
  typedef struct packed {
    logic [NSUB-1:0] sub;
    logic comp;
    logic conv;
    logic tb0;
    logic tb1;
    logic sim;
    logic uart;
  } irc_evt_t;

  // Core side request
  typedef struct packed {
    logic slot;
    logic callPush;
    logic retPop;
    logic retiPop;
    logic [PC_W-1:0] pcNext;
  } irc_core_req_t;

  // Core side answer
  typedef struct packed {
    logic pcLoad;
    logic [PC_W-1:0] pcTarget;
  } irc_core_rsp_t;
endpackage

// ==== sim/irc_core_model.sv ====
`timescale 1ns/10ps
// Core stand-in: runs a program counter, calls and returns, checks popped addresses
module irc_core_model (
  input wire logic mclk, // System clock
  input wire logic rst, // Async reset, high
  input wire irc_pkg::irc_core_rsp_t coreRsp, // PC load from controller
  input wire logic slotOn, // Core accepts interrupts
  input wire logic doCall, // Call pulse from bench
  input wire logic doRet, // Return pulse from bench
  output irc_pkg::irc_core_req_t coreReq, // Requests to controller
  output logic [7:0] loads, // PC loads seen
  output logic [irc_pkg::PC_W-1:0] lastTgt, // Last loaded target
  output logic [7:0] retErr // Wrong return addresses
);
  import irc_pkg::*;
  logic [PC_W-1:0] pcCur_r;
  logic [PC_W-1:0] prevNext_r;
  logic [PC_W-1:0] stk_r [0:8];
  logic [3:0] sp_r;
  logic retWas_r;

  // Request lines follow the bench commands
  always_comb begin
    coreReq = '0;
    coreReq.slot = slotOn;
    coreReq.callPush = doCall;
    coreReq.retiPop = doRet;
    coreReq.pcNext = pcCur_r + 13'h0001;
  end

  // Own copy of the stack; a load after a return must match it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcCur_r <= 13'h0100;
      prevNext_r <= '0;
      sp_r <= '0;
      retWas_r <= 1'b0;
      loads <= '0;
      lastTgt <= '0;
      retErr <= '0;
    end else begin
      prevNext_r <= coreReq.pcNext;
      retWas_r <= doRet && sp_r != 4'h0;
      pcCur_r <= coreRsp.pcLoad ? coreRsp.pcTarget : pcCur_r + 13'h0001;
      if (doCall && sp_r < 4'h8) begin
        stk_r[sp_r] <= coreReq.pcNext;
        sp_r <= sp_r + 4'h1;
      end else if (doRet && sp_r != 4'h0) begin
        sp_r <= sp_r - 4'h1;
      end
      if (coreRsp.pcLoad === 1'b1) begin
        loads <= loads + 8'h01;
        lastTgt <= coreRsp.pcTarget;
        if (retWas_r) begin
          if (coreRsp.pcTarget !== stk_r[sp_r]) retErr <= retErr + 8'h01;
        end else begin
          stk_r[sp_r] <= prevNext_r;
          sp_r <= sp_r + 4'h1;
        end
      end
    end
  end
endmodule

// ==== sim/irc_ctrl_test.sv ====
`timescale 1ns/10ps
module irc_ctrl_test;
  import irc_pkg::*;
  logic mclk = 0;
  logic rst = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, wakeReq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic pinA = 0, pinB = 0, lowPower = 0, slotOn = 0, doCall = 0, doRet = 0;
  irc_evt_t evt = '0;
  irc_core_req_t coreReq;
  irc_core_rsp_t coreRsp;
  logic [SP_W-1:0] stackLevel;
  logic [7:0] loads, retErr, l0;
  logic [PC_W-1:0] lastTgt;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] adr [7] = '{OFS_EDGE, OFS_PRI0, OFS_PRI1, OFS_PRI2, OFS_GRP0, OFS_GRP1, OFS_GRP2};
  logic [7:0] msk [7] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33, 8'hff, 8'h33};

  // Clock and watchdog
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end

  irc_ctrl u_dut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .extIrqPinA(pinA), .extIrqPinB(pinB), .evt(evt), .coreReq(coreReq),
    .lowPower(lowPower), .coreRsp(coreRsp), .stackLevel(stackLevel), .wakeReq(wakeReq));
  irc_core_model u_core (.mclk(mclk), .rst(rst), .coreRsp(coreRsp), .slotOn(slotOn),
    .doCall(doCall), .doRet(doRet), .coreReq(coreReq), .loads(loads), .lastTgt(lastTgt),
    .retErr(retErr));

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [PC_W-1:0] vec(input int i);
    return VEC_BASE_DEF + VEC_STEP_DEF * i[PC_W-1:0];
  endfunction

  // Register write; each channel released at its own handshake
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) begin
        rsp = bresp;
        bready <= 0;
        break;
      end
    end
  endtask

  task rdr(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        rsp = rresp;
        rready <= 0;
        break;
      end
    end
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] e);
    rdr(a);
    chk(rd, {24'h0, e});
    chk(rsp, RESP_OKAY);
  endtask

  task pulse(input irc_evt_t e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    repeat (4) @(posedge mclk);
  endtask

  // One call or return from the core
  task core(input logic r);
    @(posedge mclk);
    if (r) doRet <= 1;
    else doCall <= 1;
    @(posedge mclk);
    doRet <= 0;
    doCall <= 0;
    repeat (4) @(posedge mclk);
  endtask

  task clr;
    for (int i = 0; i < 7; i++) wr(adr[i], 8'h00);
  endtask

  task t_regs;
    for (int i = 0; i < 7; i++) rchk(adr[i], 8'h00);
    rdr(8'h1c);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    wr(8'h1c, 8'hff);
    chk(rsp, RESP_SLVERR);
    for (int i = 0; i < 7; i++) begin
      wr(adr[i], 8'hff);
      chk(rsp, RESP_OKAY);
      rchk(adr[i], msk[i]);
    end
    clr;
    $display("t_regs done");
  endtask

  task t_edges;
    logic [2:0] c;
    for (c = 0; c < 4; c++) begin
      wr(OFS_EDGE, {6'h0, c[1:0]});
      pinA <= 1;
      repeat (4) @(posedge mclk);
      rchk(OFS_PRI0, {3'h0, c[0], 4'h0});
      wr(OFS_PRI0, 8'h00);
      pinA <= 0;
      repeat (4) @(posedge mclk);
      rchk(OFS_PRI0, {3'h0, c[1], 4'h0});
      wr(OFS_PRI0, 8'h00);
    end
    wr(OFS_EDGE, 8'h04);
    pinB <= 1;
    repeat (4) @(posedge mclk);
    rchk(OFS_PRI2, 8'h20);
    rchk(OFS_PRI0, 8'h00);
    clr;
    $display("t_edges done");
  endtask

  task t_take;
    irc_evt_t e;
    e = '0;
    e.conv = 1;
    e.tb0 = 1;
    slotOn <= 1;
    l0 = loads;
    wr(OFS_PRI1, 8'h04);
    pulse(e);
    chk(loads, l0);
    rchk(OFS_PRI1, 8'hc4);
    wr(OFS_PRI0, 8'h01);
    repeat (4) @(posedge mclk);
    chk(loads, l0 + 8'h01);
    chk(lastTgt, vec(V_CONV));
    chk(stackLevel, 1);
    rchk(OFS_PRI0, 8'h00);
    rchk(OFS_PRI1, 8'h84);
    wr(OFS_PRI0, 8'h01);
    repeat (4) @(posedge mclk);
    chk(loads, l0 + 8'h01);
    core(1);
    chk(stackLevel, 0);
    chk(retErr, 0);
    clr;
    $display("t_take done");
  endtask

  task t_nest;
    irc_evt_t e;
    e = '0;
    e.conv = 1;
    wr(OFS_PRI1, 8'h0c);
    wr(OFS_PRI0, 8'h01);
    pulse(e);
    chk(lastTgt, vec(V_CONV));
    wr(OFS_PRI0, 8'h01);
    e = '0;
    e.tb0 = 1;
    pulse(e);
    chk(lastTgt, vec(V_TB0));
    chk(stackLevel, 2);
    core(1);
    core(1);
    chk(stackLevel, 0);
    chk(retErr, 0);
    clr;
    $display("t_nest done");
  endtask

  task t_full;
    irc_evt_t e;
    e = '0;
    e.conv = 1;
    repeat (8) core(0);
    chk(stackLevel, SP_FULL);
    l0 = loads;
    wr(OFS_PRI1, 8'h04);
    wr(OFS_PRI0, 8'h01);
    pulse(e);
    chk(loads, l0);
    core(1);
    chk(loads, l0 + 8'h02);
    chk(lastTgt, vec(V_CONV));
    repeat (8) core(1);
    chk(stackLevel, 0);
    chk(retErr, 0);
    clr;
    $display("t_full done");
  endtask

  task t_group;
    irc_evt_t e;
    e = '0;
    e.sub[1] = 1;
    wr(OFS_PRI0, 8'h0d);
    pulse(e);
    chk(lastTgt, vec(V_GRP0));
    rchk(OFS_GRP0, 8'h20);
    rchk(OFS_PRI0, 8'h0c);
    e = '0;
    e.comp = 1;
    e.conv = 1;
    e.sub[5] = 1;
    wr(OFS_PRI1, 8'h04);
    pulse(e);
    wr(OFS_PRI0, 8'h25);
    repeat (4) @(posedge mclk);
    chk(lastTgt, vec(V_COMP));
    rchk(OFS_PRI1, 8'h54);
    core(1);
    core(1);
    chk(stackLevel, 0);
    chk(retErr, 0);
    clr;
    $display("t_group done");
  endtask

  task t_wake;
    irc_evt_t e;
    e = '0;
    e.uart = 1;
    wr(OFS_PRI2, 8'h10);
    lowPower <= 1;
    repeat (4) @(posedge mclk);
    chk(wakeReq, 0);
    pulse(e);
    chk(wakeReq, 1);
    lowPower <= 0;
    repeat (3) @(posedge mclk);
    chk(wakeReq, 0);
    clr;
    $display("t_wake done");
  endtask

  task print_verdict;
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    t_regs;
    t_edges;
    t_take;
    t_nest;
    t_full;
    t_group;
    t_wake;
    print_verdict;
  end
endmodule
